// [core/refgen_pkg.sv]
// Package: constants for the reference generator refresh sequencer.
// Assumes a 20 MHz system clock; all other timing is derived from it.
package refgen_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 10;
  localparam int CODE_BITS = 10;
  localparam int CHAN_COUNT = 18;
  localparam int CHAN_BITS = 5;
  localparam logic [CODE_BITS-1:0] CODE_MID = 10'h200;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 10'h000;
  localparam int CODE_FULL_SCALE = 1024;
  localparam int OSC_HZ = 21_000;
  localparam int OSC_HALF_CYCLES = CLK_HZ / (2 * OSC_HZ);
  localparam int STEP_MV = 2000;
  localparam int SPAN_MV_DEFAULT = 16000;
  localparam logic [15:0] WB_ADDR_CTRL = 16'h0000;
  localparam logic [15:0] WB_ADDR_STATUS = 16'h0004;
  localparam logic [15:0] WB_ADDR_CODE_BASE = 16'h0100;
  localparam int CTRL_SPAN_LSB = 0;
  typedef enum {ST_IDLE, ST_SHIFT} link_state_t;
endpackage

// [core/code_memory.sv]
// Code memory: one stored code per channel, registered read port.
// Assumes a single clock domain and one write per cycle.
`timescale 1ns/1ns
module code_memory #(
  parameter int DEPTH = 18,
  parameter int AW = 5,
  parameter int DW = 10
)(
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

// [core/refgen_sequencer.sv]
// Top: serial frame receiver, code store, refresh clock and sequencer.
// Assumes serial and refresh pins are asynchronous; all are synchronised.
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
module refgen_sequencer
  import refgen_pkg::*;
#(
  parameter int OSC_HALF = OSC_HALF_CYCLES
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic frame_select_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_i,
  output logic serial_chain_out_o,
  input wire logic refresh_clock_pin_i,
  output logic refresh_clock_pin_o,
  output logic refresh_clock_pin_oe_o,
  input wire logic refresh_source_select_i,
  output logic [CHAN_BITS-1:0] refresh_channel_o,
  output logic [CODE_BITS-1:0] converter_code_o,
  output logic hold_switch_closed_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import refgen_pkg::*;

  function automatic logic [CHAN_BITS-1:0] next_chan(
    input logic [CHAN_BITS-1:0] c);
    next_chan = (c == CHAN_BITS'(CHAN_COUNT - 1)) ? '0 : c + 1'b1;
  endfunction

  // Two-flop synchronisers
  logic [1:0] sel_n_sync_reg, sclk_sync_reg, sdi_sync_reg, ext_sync_reg;
  logic [1:0] src_sync_reg;
  always_ff @(posedge clk_i)
  begin
    sel_n_sync_reg <= {sel_n_sync_reg[0], frame_select_n_i};
    sclk_sync_reg <= {sclk_sync_reg[0], serial_clk_i};
    sdi_sync_reg <= {sdi_sync_reg[0], serial_in_i};
    ext_sync_reg <= {ext_sync_reg[0], refresh_clock_pin_i};
    src_sync_reg <= {src_sync_reg[0], refresh_source_select_i};
  end
  wire sel_n = sel_n_sync_reg[1];
  wire sclk = sclk_sync_reg[1];
  wire serial_in = sdi_sync_reg[1];

  logic sclk_d_reg, sel_n_d_reg;
  always_ff @(posedge clk_i)
  begin
    sclk_d_reg <= rst_i ? 1'b0 : sclk;
    sel_n_d_reg <= rst_i ? 1'b1 : sel_n;
  end
  wire sclk_rise = sclk & ~sclk_d_reg & ~sel_n;
  wire sclk_fall = ~sclk & sclk_d_reg & ~sel_n;
  wire frame_end = sel_n & ~sel_n_d_reg;

  // Serial shift register and chain output
  logic [FRAME_BITS-1:0] shift_reg;
  logic [4:0] bit_count_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shift_reg <= '0;
      bit_count_reg <= '0;
      serial_chain_out_o <= 1'b0;
    end
    else
    begin
      if (sclk_rise)
      begin
        shift_reg <= {shift_reg[FRAME_BITS-2:0], serial_in};
        if (bit_count_reg != 5'h10)
        begin
          bit_count_reg <= bit_count_reg + 1'b1;
        end
      end
      // Bit 15 now holds the bit taken sixteen edges ago
      if (sclk_fall)
      begin
        serial_chain_out_o <= shift_reg[FRAME_BITS-1];
      end
      if (frame_end)
      begin
        bit_count_reg <= '0;
      end
    end
  end

  wire [CHAN_BITS-1:0] frame_chan = shift_reg[ADDR_HI:ADDR_LO];
  wire [CODE_BITS-1:0] frame_code = shift_reg[CODE_BITS-1:0];
  // Partial frames and out-of-range addresses are ignored
  wire frame_write = frame_end && bit_count_reg == 5'h10 &&
    frame_chan < CHAN_BITS'(CHAN_COUNT);

  // Software control: step span in mV for the slew limiter
  logic [15:0] span_mv_reg;
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Write lands on the edge that sees ack, as the master expects
  wire wb_wr_ctrl = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i &
    (wb_adr_i == WB_ADDR_CTRL);
  wire wb_code_hit = wb_adr_i >= WB_ADDR_CODE_BASE &&
    wb_adr_i < WB_ADDR_CODE_BASE + 16'(CHAN_COUNT * 4);
  wire [15:0] wb_code_off = wb_adr_i - WB_ADDR_CODE_BASE;

  // Code store, read by the refresh sequencer
  logic [CHAN_BITS-1:0] chan_reg;
  logic [CODE_BITS-1:0] mem_rdata;
  code_memory #(
    .DEPTH(CHAN_COUNT),
    .AW(CHAN_BITS),
    .DW(CODE_BITS)
  ) u_codes (
    .clk_i(clk_i),
    .we_i(frame_write),
    .waddr_i(frame_chan),
    .wdata_i(frame_code),
    .raddr_i(chan_reg),
    .rdata_o(mem_rdata)
  );

  // Internal oscillator and source selection
  logic [15:0] osc_count_reg;
  logic osc_reg, ext_mode_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_count_reg <= '0;
      osc_reg <= 1'b0;
      ext_mode_reg <= 1'b0;
    end
    else
    begin
      ext_mode_reg <= src_sync_reg[1];
      if (osc_count_reg == 16'(OSC_HALF - 1))
      begin
        osc_count_reg <= '0;
        osc_reg <= ~osc_reg;
      end
      else
      begin
        osc_count_reg <= osc_count_reg + 1'b1;
      end
    end
  end
  wire refresh_clk = ext_mode_reg ? ext_sync_reg[1] : osc_reg;

  // Pin stays undriven until the first internal edge after reset
  logic pin_armed_reg, refresh_d_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_armed_reg <= 1'b0;
      refresh_clock_pin_o <= 1'b0;
      refresh_clock_pin_oe_o <= 1'b0;
      // Low like the oscillator, so reset shows no false fall
      refresh_d_reg <= 1'b0;
    end
    else
    begin
      if (osc_count_reg == 16'(OSC_HALF - 1))
      begin
        pin_armed_reg <= 1'b1;
      end
      refresh_clock_pin_o <= osc_reg;
      refresh_clock_pin_oe_o <= pin_armed_reg & ~ext_mode_reg;
      refresh_d_reg <= refresh_clk;
    end
  end
  wire refresh_fall = refresh_d_reg & ~refresh_clk;
  wire refresh_rise = ~refresh_d_reg & refresh_clk;

  // Slew-limited converter code per refresh; one step per visit
  logic [CODE_BITS:0] step_code;
  always_comb
  begin
    step_code = (CODE_BITS+1)'((32'(CODE_FULL_SCALE) * STEP_MV) /
      ((span_mv_reg == 16'h0000) ? 32'd1 : 32'(span_mv_reg)));
  end
  logic [CODE_BITS-1:0] applied_reg [CHAN_COUNT];
  wire [CODE_BITS-1:0] cur = applied_reg[chan_reg];
  wire [CODE_BITS:0] up_lim = {1'b0, cur} + step_code;
  wire [CODE_BITS:0] dn_gap = {1'b0, cur} - {1'b0, mem_rdata};
  wire [CODE_BITS:0] up_gap = {1'b0, mem_rdata} - {1'b0, cur};
  wire [CODE_BITS-1:0] slewed =
    (mem_rdata > cur) ? ((up_gap > step_code) ? up_lim[CODE_BITS-1:0]
                                              : mem_rdata)
                      : ((dn_gap > step_code) ?
                          CODE_BITS'(cur - step_code[CODE_BITS-1:0])
                                              : mem_rdata);

  // Sequencer: switches close on falling edge, open on rising
  logic first_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      chan_reg <= '0;
      first_reg <= 1'b1;
      hold_switch_closed_o <= 1'b0;
      refresh_channel_o <= '0;
      converter_code_o <= CODE_RESET;
      for (int i = 0; i < CHAN_COUNT; i++)
      begin
        applied_reg[i] <= CODE_RESET;
      end
    end
    else if (refresh_fall)
    begin
      hold_switch_closed_o <= 1'b1;
      refresh_channel_o <= chan_reg;
      converter_code_o <= slewed;
      applied_reg[chan_reg] <= slewed;
      first_reg <= 1'b0;
    end
    else if (refresh_rise)
    begin
      hold_switch_closed_o <= 1'b0;
      if (!first_reg)
      begin
        chan_reg <= next_chan(chan_reg);
      end
    end
  end

  // Wishbone slave: one-cycle registered ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      span_mv_reg <= 16'(SPAN_MV_DEFAULT);
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_wr_ctrl && wb_sel_i[0])
      begin
        span_mv_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_wr_ctrl && wb_sel_i[1])
      begin
        span_mv_reg[15:8] <= wb_dat_i[15:8];
      end
      if (wb_req)
      begin
        if (wb_adr_i == WB_ADDR_CTRL)
          wb_dat_o <= {16'h0000, span_mv_reg};
        else if (wb_adr_i == WB_ADDR_STATUS)
          wb_dat_o <= {16'h0000, 8'h00, ext_mode_reg, hold_switch_closed_o,
                       1'b0, chan_reg};
        else if (wb_code_hit)
          wb_dat_o <= {22'h00_0000,
                       applied_reg[CHAN_BITS'(wb_code_off[15:2])]};
        else
          wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // Checks
  sequence fall_seq;
    refresh_fall;
  endsequence
  channel_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    refresh_rise && !first_reg && chan_reg == 5'd17 |=> chan_reg == 5'd0)
    else $error("channel did not wrap");
  switch_close_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fall_seq |=> hold_switch_closed_o)
    else $error("switch not closed on falling edge");
  switch_open_a: assert property (@(posedge clk_i) disable iff (rst_i)
    refresh_rise |=> !hold_switch_closed_o)
    else $error("switch not opened on rising edge");
  channel_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chan_reg < 5'd18)
    else $error("channel out of range");
  channel_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    refresh_rise && !first_reg && chan_reg < 5'd17 |=>
    chan_reg == $past(chan_reg) + 5'd1)
    else $error("channel did not advance");
  pin_ext_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_mode_reg |=> !refresh_clock_pin_oe_o)
    else $error("pin driven in external mode");
  pin_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    refresh_clock_pin_oe_o |-> refresh_clock_pin_o == $past(osc_reg))
    else $error("pin not following oscillator");
  frame_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sclk_rise |=> shift_reg[0] == $past(serial_in))
    else $error("serial bit not shifted");
  chain_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sclk_fall |=> serial_chain_out_o == $past(shift_reg[15]))
    else $error("chain output wrong");
endmodule

// [testbench/host_serial.sv]
// Host side of the three-wire link: sends frames, records chain data.
// Assumes the device samples these pins with its own unrelated clock.
`timescale 1ns/1ns
module host_serial (
  output logic frame_select_n_o,
  output logic serial_clk_o,
  output logic serial_in_o,
  input wire logic serial_chain_out_i
);
  logic [15:0] chain_q[$];
  initial
  begin
    frame_select_n_o = 1'b1;
    serial_clk_o = 1'b0;
    serial_in_o = 1'b0;
  end
  // Clock parked low outside frames; 400 ns period, odd phase
  task automatic send(input logic [31:0] v, input int n);
    logic [15:0] c;
    c = 16'h0000;
    #13 frame_select_n_o = 1'b0;
    for (int k = 0; k < n; k++)
    begin
      #100 serial_in_o = v[n-1-k];
      #100;
      // Chain bit needs up to three device clocks after the fall
      if (k >= 16) c = {c[14:0], serial_chain_out_i};
      serial_clk_o = 1'b1;
      #200 serial_clk_o = 1'b0;
    end
    #100 frame_select_n_o = 1'b1;
    // Released line shows the inverse, never a stale bit
    serial_in_o = ~serial_in_o;
    chain_q.push_back(c);
    #400;
  endtask
endmodule

// [testbench/tb.sv]
// Bench: serial host, refresh clock and bus master around the sequencer.
// Assumes the internal oscillator half period is cut to HALF cycles.
`timescale 1ns/1ns
module tb;
  import refgen_pkg::*;
  localparam int HALF = 5;
  localparam int EXT_HALF = 144;
  localparam int LIMIT = 60000;
  localparam int STEP = CODE_FULL_SCALE * STEP_MV / SPAN_MV_DEFAULT;
  logic clk_i = 1'b0, rst_i = 1'b1, sel_i = 1'b1, pin_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [15:0] adr = 16'h0000, f1;
  logic [3:0] bsel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, rdat, q;
  logic fsn, sclk, serial_in, serial_chain_out, pin_o, oe, hold, hold_q, ack;
  logic [CHAN_BITS-1:0] ch;
  logic [CODE_BITS-1:0] code;
  int num_errors = 0, check_count = 0, cyc_n = 0, wid = 0, wchk = 0;
  int tgt[CHAN_COUNT], app[CHAN_COUNT], exp_ch = 0, seed = 86446;
  time t0;
  // Pin level: device drives when enabled, else the bench
  wire pin_w = oe ? pin_o : pin_i;
  refgen_sequencer #(.OSC_HALF(HALF)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .frame_select_n_i(fsn),
    .serial_clk_i(sclk), .serial_in_i(serial_in), .serial_chain_out_o(serial_chain_out),
    .refresh_clock_pin_i(pin_w), .refresh_clock_pin_o(pin_o),
    .refresh_clock_pin_oe_o(oe), .refresh_source_select_i(sel_i),
    .refresh_channel_o(ch), .converter_code_o(code),
    .hold_switch_closed_o(hold), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  host_serial u_host (.frame_select_n_o(fsn), .serial_clk_o(sclk),
    .serial_in_o(serial_in), .serial_chain_out_i(serial_chain_out));
  initial forever #25 clk_i = ~clk_i;
  task automatic results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] e,
      input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", s, e, g);
    end
  endtask
  function automatic int slew(input int a, input int t);
    if (t > a + STEP) return a + STEP;
    if (t < a - STEP) return a - STEP;
    return t;
  endfunction
  function automatic logic [15:0] frame(input int c, input int v);
    return {1'b0, c[4:0], v[9:0]};
  endfunction
  task automatic wb(input logic w, input logic [15:0] a,
      input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    {cyc, stb, we, adr, dat, bsel} <= {2'b11, w, a, d, s};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100) check("ack", 1, 0);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic rd(input string s, input logic [15:0] a,
      input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000, 4'hf);
    check(s, e, q);
  endtask
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == LIMIT)
    begin
      num_errors++;
      $display("[ERR] timeout expected %0d seen %0d", LIMIT, cyc_n);
      results;
    end
  end
  always @(posedge clk_i)
  begin
    hold_q <= hold;
    wid <= hold ? wid + 1 : 0;
    if (!hold && hold_q && wchk != 0) check("width", wchk, wid);
    if (hold && !hold_q && !rst_i)
    begin
      check("channel", exp_ch, ch);
      app[exp_ch] = slew(app[exp_ch], tgt[exp_ch]);
      check("code", app[exp_ch], code);
      if (sel_i) check("pin low", 0, pin_w);
      exp_ch = (exp_ch + 1) % CHAN_COUNT;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("oe", 0, oe);
    check("hold", 0, hold);
    wb(1'b1, WB_ADDR_CTRL, 32'hFFFF_3E80, 4'h3);
    rd("ctrl", WB_ADDR_CTRL, 32'h0000_3E80);
    wb(1'b1, 16'h0200, 32'h0000_00FF, 4'hf);
    rd("unmapped", 16'h0200, 32'h0000_0000);
    $display("test bus done");
    for (int c = 0; c < CHAN_COUNT - 1; c++)
    begin
      tgt[c] = (c == 0) ? 512 : $random(seed) & 1023;
      u_host.send({16'h0000, frame(c, tgt[c])}, 16);
    end
    u_host.send({16'h0000, frame(20, 7)}, 16);
    u_host.send(32'(frame(1, 5) >> 8), 8);
    f1 = 16'($random(seed));
    tgt[17] = 1023;
    u_host.send({f1, frame(17, 1023)}, 32);
    check("chain", f1, u_host.chain_q[$]);
    $display("test frames done");
    repeat (10) @(posedge clk_i);
    check("oe ext", 0, oe);
    wchk = EXT_HALF;
    repeat (9 * CHAN_COUNT)
    begin
      repeat (EXT_HALF) @(posedge clk_i);
      pin_i <= 1'b0;
      // Rising edge kept clear of any other stimulus change
      repeat (EXT_HALF) @(posedge clk_i);
      pin_i <= 1'b1;
    end
    repeat (8) @(posedge clk_i);
    rd("applied", WB_ADDR_CODE_BASE + 16'h0044, 32'(app[17]));
    rd("status", WB_ADDR_STATUS, 32'h0000_0080);
    $display("test external done");
    sel_i <= 1'b0;
    wchk = 0;
    for (int n = 0; n < 100 && oe !== 1'b1; n++) @(posedge clk_i);
    check("oe int", 1, oe);
    repeat (4 * HALF) @(posedge clk_i);
    wchk = HALF;
    @(posedge pin_o);
    t0 = $time;
    @(posedge pin_o);
    check("osc period", 2 * HALF * 50, 32'($time - t0));
    repeat (400) @(posedge clk_i);
    $display("test internal done");
    results;
  end
endmodule
